// File: inc/pia_pkg.sv
// Constants of the priority interrupt arbiter: register word indices,
// field positions, reset values and widths.
// Assumes APB byte addresses equal to four times the word index.
package pia_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int PIA_NSRC = 64;
    localparam int PIA_NPRIO = 8;
    localparam int PIA_VBASE_W = 14;
    localparam int PIA_FVH_W = 5;
    localparam int PIA_ADDR_W = 21;
    localparam int PIA_NST = 3;

    // ------------------------------------------------------------------
    // Register word indices (byte address = 4 * index)
    // ------------------------------------------------------------------
    localparam logic [4:0] PIA_IDX_PRIO0 = 5'h00;
    localparam logic [4:0] PIA_IDX_VBASE = 5'h07;
    localparam logic [4:0] PIA_IDX_FM0 = 5'h08;
    localparam logic [4:0] PIA_IDX_FVL0 = 5'h09;
    localparam logic [4:0] PIA_IDX_FVH0 = 5'h0a;
    localparam logic [4:0] PIA_IDX_FM1 = 5'h0b;
    localparam logic [4:0] PIA_IDX_FVL1 = 5'h0c;
    localparam logic [4:0] PIA_IDX_FVH1 = 5'h0d;
    localparam logic [4:0] PIA_IDX_PEND0 = 5'h0e;
    localparam logic [4:0] PIA_IDX_PRIO7 = 5'h12;
    localparam logic [4:0] PIA_IDX_CTRL = 5'h16;
    localparam logic [4:0] PIA_IDX_STAT = 5'h17;
    localparam logic [4:0] PIA_IDX_CLR = 5'h18;
    localparam logic [4:0] PIA_IDX_IEN = 5'h19;

    // ------------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------------
    localparam int PIA_CTRL_LVL_LSB = 0;
    localparam int PIA_CTRL_FAST_BIT = 2;
    localparam int PIA_CTRL_EN_BIT = 5;
    localparam int PIA_ST_PRESENT = 0;
    localparam int PIA_ST_FAST = 1;
    localparam int PIA_ST_WAKE = 2;
    localparam logic [15:0] PIA_PRIO_RST = 16'h0000;
    localparam logic [13:0] PIA_VBASE_RST = 14'h0000;
    localparam logic [5:0] PIA_FM_RST = 6'h00;
    localparam logic [15:0] PIA_FVL_RST = 16'h0000;
    localparam logic [4:0] PIA_FVH_RST = 5'h00;
    localparam logic PIA_EN_RST = 1'b1;
    localparam logic [63:0] PIA_FIXED_L3 = 64'h0000_0000_0000_0003;

endpackage

// File: src/pia_arbiter.sv
// Priority interrupt arbiter: APB register slave, per-level priority
// encoders, vector address and fast-vector selection, wake request.
// Assumes requests and core mask bits come from logic on pclk.
`timescale 1ns/1ns

module pia_arbiter #(
    parameter logic [63:0] FIXED_L3 = pia_pkg::PIA_FIXED_L3
) (
    // Clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Interrupt sources
    input wire logic [pia_pkg::PIA_NSRC-1:0] irq_src,
    // Core side
    input wire logic core_mask_bit_high,
    input wire logic core_mask_bit_low,
    output logic core_irq,
    output logic [1:0] core_level,
    output logic [1:0] presented_level,
    output logic [5:0] vector_num,
    output logic [pia_pkg::PIA_ADDR_W-1:0] vector_addr,
    output logic fast_irq,
    // System integration unit
    input wire logic low_power_mode,
    output logic wake_req,
    // Status interrupt
    output logic irq
);
    import pia_pkg::*;

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [15:0] prio_ff [PIA_NPRIO];
    logic [PIA_VBASE_W-1:0] vector_base_ff;
    logic [5:0] fast_match_0_ff;
    logic [5:0] fast_match_1_ff;
    logic [15:0] fvl_ff [2];
    logic [PIA_FVH_W-1:0] fvh_ff [2];
    logic arb_en_ff;
    logic [PIA_NST-1:0] st_ff;
    logic [PIA_NST-1:0] ien_ff;
    logic [31:0] prdata_ff;
    logic core_irq_ff;
    logic [1:0] core_level_ff;
    logic [1:0] presented_level_ff;
    logic [5:0] vector_num_ff;
    logic [PIA_ADDR_W-1:0] vector_addr_ff;
    logic fast_ff;
    logic [PIA_NSRC-1:0] wake_snap_ff;
    logic low_power_ff;
    logic wake_prev_ff;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    logic [4:0] idx;
    logic mapped;
    logic wr_en;
    logic setup;
    logic [31:0] rd_mux;
    assign idx = paddr[6:2];
    assign setup = psel && !penable && ce;
    assign wr_en = psel && penable && pwrite && ce && mapped;
    assign mapped = !paddr[7] && paddr[1:0] == 2'b00 &&
        (idx <= PIA_IDX_PRIO7 || idx == PIA_IDX_CTRL ||
         idx == PIA_IDX_STAT || idx == PIA_IDX_CLR || idx == PIA_IDX_IEN);

    // Stalled while frozen so no write is lost
    assign pready = ce;
    assign pslverr = psel && penable && !mapped;
    assign prdata = prdata_ff;

    // ------------------------------------------------------------------
    // Level sorting and priority encoding
    // ------------------------------------------------------------------
    logic [PIA_NSRC-1:0] req_lvl [4];
    logic [1:0] field [PIA_NSRC];
    for (genvar s = 0; s < PIA_NSRC; s++) begin : g_src
        assign field[s] = prio_ff[s / 8][2 * (s % 8) +: 2];
        // Field 00 disables a source; fixed sources always sit at level 3
        assign req_lvl[0][s] = irq_src[s] && !FIXED_L3[s] &&
            field[s] == 2'b01;
        assign req_lvl[1][s] = irq_src[s] && !FIXED_L3[s] &&
            field[s] == 2'b10;
        assign req_lvl[2][s] = irq_src[s] && !FIXED_L3[s] &&
            field[s] == 2'b11;
        assign req_lvl[3][s] = irq_src[s] && FIXED_L3[s];
    end
    function automatic logic [5:0] lowest(input logic [63:0] v);
        logic [5:0] r;
        r = 6'h00;
        for (int i = 63; i >= 0; i--) begin
            if (v[i]) begin
                r = 6'(i);
            end
        end
        return r;
    endfunction
    logic [1:0] mask_lvl;
    logic win_any;
    logic [1:0] win_lvl;
    logic [63:0] win_vec;
    logic [5:0] win_num;
    logic win_fast;
    logic [PIA_ADDR_W-1:0] win_addr;
    assign mask_lvl = {core_mask_bit_high, core_mask_bit_low};
    always_comb begin
        win_any = 1'b0;
        win_lvl = 2'd0;
        // Highest pending level at or above the mask wins
        for (int l = 0; l < 4; l++) begin
            if (|req_lvl[l] && 2'(l) >= mask_lvl && arb_en_ff) begin
                win_any = 1'b1;
                win_lvl = 2'(l);
            end
        end
        win_vec = req_lvl[win_lvl];
        win_num = lowest(win_vec);
        // Fast match resolved here, before the core sees the request
        win_fast = win_any && win_lvl == 2'd2 &&
            (win_num == fast_match_0_ff || win_num == fast_match_1_ff);
        win_addr = {1'b0, vector_base_ff, win_num};
        if (win_fast) begin
            win_addr = (win_num == fast_match_0_ff) ? {fvh_ff[0], fvl_ff[0]} :
                {fvh_ff[1], fvl_ff[1]};
        end
    end

    // ------------------------------------------------------------------
    // Core-facing outputs
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_irq_ff <= 1'b0;
            core_level_ff <= 2'd0;
            presented_level_ff <= 2'b00;
            vector_num_ff <= 6'h00;
            vector_addr_ff <= '0;
            fast_ff <= 1'b0;
        end else if (ce) begin
            core_irq_ff <= win_any;
            core_level_ff <= win_lvl;
            vector_num_ff <= win_num;
            vector_addr_ff <= win_addr;
            fast_ff <= win_fast;
            presented_level_ff <= !win_any ? 2'b00 :
                (win_lvl >= 2'd2) ? 2'b11 : win_lvl + 2'd1;
        end
    end
    assign core_irq = core_irq_ff;
    assign core_level = core_level_ff;
    assign presented_level = presented_level_ff;
    assign vector_num = vector_num_ff;
    assign vector_addr = vector_addr_ff;
    assign fast_irq = fast_ff;

    // ------------------------------------------------------------------
    // Low-power wake
    // ------------------------------------------------------------------
    logic [PIA_NSRC-1:0] enabled;
    for (genvar s = 0; s < PIA_NSRC; s++) begin : g_en
        assign enabled[s] = FIXED_L3[s] || field[s] != 2'b00;
    end
    // Snapshot taken on entry; later enables cannot wake the core
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_power_ff <= 1'b0;
            wake_snap_ff <= '0;
        end else if (ce) begin
            low_power_ff <= low_power_mode;
            if (low_power_mode && !low_power_ff) begin
                wake_snap_ff <= enabled;
            end
        end
    end
    // Combinational so it still works once clocks are stopped
    assign wake_req = low_power_mode && low_power_ff &&
        |(irq_src & wake_snap_ff);

    // ------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prio_ff <= '{default: PIA_PRIO_RST};
            vector_base_ff <= PIA_VBASE_RST;
            fast_match_0_ff <= PIA_FM_RST;
            fast_match_1_ff <= PIA_FM_RST;
            fvl_ff <= '{default: PIA_FVL_RST};
            fvh_ff <= '{default: PIA_FVH_RST};
            arb_en_ff <= PIA_EN_RST;
            ien_ff <= '0;
        end else if (wr_en) begin
            case (idx)
                PIA_IDX_VBASE: vector_base_ff <= pwdata[PIA_VBASE_W-1:0];
                PIA_IDX_FM0: fast_match_0_ff <= pwdata[5:0];
                PIA_IDX_FVL0: fvl_ff[0] <= pwdata[15:0];
                PIA_IDX_FVH0: fvh_ff[0] <= pwdata[PIA_FVH_W-1:0];
                PIA_IDX_FM1: fast_match_1_ff <= pwdata[5:0];
                PIA_IDX_FVL1: fvl_ff[1] <= pwdata[15:0];
                PIA_IDX_FVH1: fvh_ff[1] <= pwdata[PIA_FVH_W-1:0];
                PIA_IDX_PRIO7: prio_ff[7] <= pwdata[15:0];
                PIA_IDX_CTRL: arb_en_ff <= pwdata[PIA_CTRL_EN_BIT];
                PIA_IDX_IEN: ien_ff <= pwdata[PIA_NST-1:0];
                default: begin
                    if (idx < PIA_IDX_VBASE) begin
                        prio_ff[idx[2:0]] <= pwdata[15:0];
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Status interrupt: set wins over clear
    // ------------------------------------------------------------------
    logic [PIA_NST-1:0] ev;
    logic [PIA_NST-1:0] clr;
    assign ev[PIA_ST_PRESENT] = win_any && !core_irq_ff;
    assign ev[PIA_ST_FAST] = win_fast && !fast_ff;
    assign ev[PIA_ST_WAKE] = wake_req && !wake_prev_ff;
    assign clr = (wr_en && idx == PIA_IDX_CLR) ? pwdata[PIA_NST-1:0] : '0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
            wake_prev_ff <= 1'b0;
        end else if (ce) begin
            st_ff <= (st_ff & ~clr) | ev;
            wake_prev_ff <= wake_req;
        end
    end
    assign irq = |(st_ff & ien_ff);

    // ------------------------------------------------------------------
    // Read data, latched in the setup cycle
    // ------------------------------------------------------------------
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (idx)
            PIA_IDX_VBASE: rd_mux[PIA_VBASE_W-1:0] = vector_base_ff;
            PIA_IDX_FM0: rd_mux[5:0] = fast_match_0_ff;
            PIA_IDX_FVL0: rd_mux[15:0] = fvl_ff[0];
            PIA_IDX_FVH0: rd_mux[PIA_FVH_W-1:0] = fvh_ff[0];
            PIA_IDX_FM1: rd_mux[5:0] = fast_match_1_ff;
            PIA_IDX_FVL1: rd_mux[15:0] = fvl_ff[1];
            PIA_IDX_FVH1: rd_mux[PIA_FVH_W-1:0] = fvh_ff[1];
            PIA_IDX_PRIO7: rd_mux[15:0] = prio_ff[7];
            PIA_IDX_CTRL: begin
                rd_mux[PIA_CTRL_LVL_LSB +: 2] = presented_level_ff;
                rd_mux[PIA_CTRL_FAST_BIT] = fast_ff;
                rd_mux[PIA_CTRL_EN_BIT] = arb_en_ff;
            end
            PIA_IDX_STAT: rd_mux[PIA_NST-1:0] = st_ff;
            PIA_IDX_IEN: rd_mux[PIA_NST-1:0] = ien_ff;
            default: begin
                if (idx < PIA_IDX_VBASE) begin
                    rd_mux[15:0] = prio_ff[idx[2:0]];
                end else if (idx >= PIA_IDX_PEND0 && idx < PIA_IDX_PRIO7) begin
                    rd_mux[15:0] = irq_src[16 * (idx - PIA_IDX_PEND0) +: 16];
                end
            end
        endcase
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0000_0000;
        end else if (setup) begin
            prdata_ff <= mapped && !pwrite ? rd_mux : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_lowest_wins;
        win_any |-> win_vec[win_num] &&
            (win_vec & ((64'h1 << win_num) - 64'h1)) == 64'h0;
    endproperty
    a_lowest_wins: assert property (p_lowest_wins)
        else $error("winner is not the lowest active source");
    property p_fixed_level3;
        ce && arb_en_ff && |(irq_src & FIXED_L3) |=>
            core_irq_ff && core_level_ff == 2'd3;
    endproperty
    a_fixed_level3: assert property (p_fixed_level3)
        else $error("pending level 3 not presented");
    property p_signal_core;
        ce && win_any |=> core_irq_ff;
    endproperty
    a_signal_core: assert property (p_signal_core)
        else $error("acceptable request not signalled");
    property p_mask_respected;
        $past(ce) && core_irq_ff |-> core_level_ff >= $past(mask_lvl);
    endproperty
    a_mask_respected: assert property (p_mask_respected)
        else $error("masked level presented");
    property p_normal_addr;
        $past(ce) && core_irq_ff && !fast_ff |->
            vector_addr_ff == {1'b0, $past(vector_base_ff), vector_num_ff};
    endproperty
    a_normal_addr: assert property (p_normal_addr)
        else $error("normal vector address wrong");
    property p_fast_match;
        $past(ce) && fast_ff |-> core_level_ff == 2'd2 &&
            (vector_num_ff == $past(fast_match_0_ff) ||
             vector_num_ff == $past(fast_match_1_ff));
    endproperty
    a_fast_match: assert property (p_fast_match)
        else $error("fast flagged without level 2 match");
    property p_fast_addr;
        $past(ce) && fast_ff && vector_num_ff == $past(fast_match_0_ff) |->
            vector_addr_ff == {$past(fvh_ff[0]), $past(fvl_ff[0])};
    endproperty
    a_fast_addr: assert property (p_fast_addr)
        else $error("fast vector address wrong");
    property p_level_code;
        core_irq_ff |-> presented_level_ff ==
            (core_level_ff >= 2'd2 ? 2'b11 : core_level_ff + 2'd1);
    endproperty
    a_level_code: assert property (p_level_code)
        else $error("presented level code wrong");
    property p_wake;
        wake_req |-> low_power_mode && |(irq_src & wake_snap_ff);
    endproperty
    a_wake: assert property (p_wake)
        else $error("wake without snapshot-enabled request");
    property p_unmapped;
        psel && penable && paddr[7] |-> pslverr;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped access not flagged");

    c_fast: cover property (ce && win_fast ##1 fast_ff);
    c_nest: cover property (core_irq_ff && core_level_ff == 2'd1
        ##1 core_irq_ff && core_level_ff == 2'd3);
    c_wake: cover property (wake_req);
    c_irq: cover property (irq);
endmodule // pia_arbiter

// File: bench/pia_core_model.sv
// Behavioural model of the core that takes arbiter requests.
// Assumes the bench drives load, mask_in and take after a rising edge.
`timescale 1ns/1ns
module pia_core_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Bench control
    input wire logic load,
    input wire logic [1:0] mask_in,
    input wire logic take,
    // Arbiter side
    input wire logic core_irq,
    input wire logic [1:0] core_level,
    input wire logic fast_irq,
    output logic core_mask_bit_high,
    output logic core_mask_bit_low,
    output logic fast_taken
);
    logic [1:0] mask_ff;
    logic fast_ff;

    // Taking a level 0 to 2 request lifts the mask past its level, so only a
    // higher level can nest; level 3 sets the top mask value, which still admits level 3
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_ff <= 2'h0;
        end else if (take && core_irq) begin
            mask_ff <= (core_level == 2'h3) ? 2'h3 : core_level + 2'h1;
        end else if (load) begin
            mask_ff <= mask_in;
        end
    end

    // The vector word is taken as not a subroutine jump
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fast_ff <= 1'b0;
        end else begin
            fast_ff <= take && core_irq && fast_irq;
        end
    end

    assign core_mask_bit_high = mask_ff[1];
    assign core_mask_bit_low = mask_ff[0];
    assign fast_taken = fast_ff;
endmodule // pia_core_model

// File: bench/tb.sv
// Self-checking bench for the priority interrupt arbiter.
// Assumes zero wait state APB answers while ce is high.
`timescale 1ns/1ns
module tb;
    import pia_pkg::*;
    localparam logic [13:0] VB = 14'h1abc;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic ce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [63:0] irq_src = 64'h0;
    logic low_power_mode = 1'b0;
    logic load = 1'b0;
    logic [1:0] mask_in = 2'h0;
    logic take = 1'b0;
    logic [31:0] prdata, rdat;
    logic pready, pslverr, rerr, core_irq, fast_irq, wake_req, irq;
    logic mhi, mlo, fast_taken;
    logic [1:0] core_level, presented_level;
    logic [5:0] vector_num;
    logic [PIA_ADDR_W-1:0] vector_addr;
    logic [15:0] sh [0:7] = '{default: 16'h0};
    int fail_count = 0;
    int n_tests = 0;

    always #50 pclk = ~pclk;

    pia_arbiter DUT (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irq_src(irq_src), .core_mask_bit_high(mhi),
        .core_mask_bit_low(mlo), .core_irq(core_irq),
        .core_level(core_level), .presented_level(presented_level),
        .vector_num(vector_num), .vector_addr(vector_addr),
        .fast_irq(fast_irq), .low_power_mode(low_power_mode),
        .wake_req(wake_req), .irq(irq));

    pia_core_model u_core (.pclk(pclk), .presetn(presetn), .load(load),
        .mask_in(mask_in), .take(take), .core_irq(core_irq),
        .core_level(core_level), .fast_irq(fast_irq),
        .core_mask_bit_high(mhi), .core_mask_bit_low(mlo),
        .fast_taken(fast_taken));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic wrap_up;
        $display("checks %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
            fail_count++;
        end
    endtask

    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [4:0] i,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {1'b0, i, 2'b00};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            fail_count++;
            wrap_up();
        end
    endtask

    task automatic wr(input logic [4:0] i, input logic [31:0] d);
        apb(1'b1, i, d);
    endtask

    task automatic rd(input logic [4:0] i, input logic [31:0] exp);
        apb(1'b0, i, 32'h0);
        chk(rdat, exp);
    endtask

    task automatic set_pri(input int s, input logic [1:0] f);
        sh[s/8][2*(s%8) +: 2] = f;
        wr((s < 56) ? 5'(s/8) : PIA_IDX_PRIO7, {16'h0, sh[s/8]});
    endtask

    task automatic look;
        @(posedge pclk);
        @(negedge pclk);
    endtask

    task automatic src(input logic [63:0] v);
        @(posedge pclk);
        irq_src <= v;
        look();
    endtask

    task automatic set_mask(input logic [1:0] m);
        @(posedge pclk);
        load <= 1'b1;
        mask_in <= m;
        @(posedge pclk);
        load <= 1'b0;
    endtask

    task automatic take_it;
        @(posedge pclk);
        take <= 1'b1;
        @(posedge pclk);
        take <= 1'b0;
        @(negedge pclk);
    endtask

    task automatic chk_core(input logic i, input logic [1:0] l,
                            input logic [5:0] v);
        logic [1:0] pc;
        pc = !i ? 2'h0 : (l == 2'h0) ? 2'h1 : (l == 2'h1) ? 2'h2 : 2'h3;
        chk({30'h0, presented_level}, {30'h0, pc});
        chk({31'h0, core_irq}, {31'h0, i});
        if (i) begin
            chk({24'h0, core_level, vector_num}, {24'h0, l, v});
        end
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_regs;
        rd(PIA_IDX_VBASE, 32'h0);
        rd(PIA_IDX_FM0, 32'h0);
        rd(PIA_IDX_CTRL, 32'h20);
        apb(1'b1, 5'h13, 32'h5);
        chk({31'h0, rerr}, 32'h1);
        apb(1'b0, 5'h1f, 32'h0);
        chk({31'h0, rerr}, 32'h1);
        chk(rdat, 32'h0);
        wr(PIA_IDX_VBASE, {18'h0, VB});
        rd(PIA_IDX_VBASE, {18'h0, VB});
        $display("end t_regs");
    endtask

    task automatic t_within;
        set_pri(3, 2'h1);
        set_pri(5, 2'h1);
        set_pri(63, 2'h1);
        set_pri(0, 2'h1);
        src(64'h28);
        chk_core(1'b1, 2'h0, 6'h03);
        chk({11'h0, vector_addr}, {12'h0, VB, 6'h03});
        rd(PIA_IDX_PEND0, 32'h28);
        src(64'h8000_0000_0000_0000);
        chk_core(1'b1, 2'h0, 6'h3f);
        src(64'h9);
        chk_core(1'b1, 2'h3, 6'h00);
        rd(PIA_IDX_CTRL, 32'h23);
        wr(PIA_IDX_CTRL, 32'h0);
        look();
        chk_core(1'b0, 2'h0, 6'h00);
        wr(PIA_IDX_CTRL, 32'h20);
        look();
        chk_core(1'b1, 2'h3, 6'h00);
        src(64'h0);
        chk_core(1'b0, 2'h0, 6'h00);
        $display("end t_within");
    endtask

    task automatic t_mask;
        int srcs [4] = '{3, 4, 6, 0};
        set_pri(4, 2'h2);
        set_pri(6, 2'h3);
        for (int l = 0; l < 4; l++) begin
            for (int m = 0; m < 4; m++) begin
                set_mask(2'(m));
                src(64'h1 << srcs[l]);
                chk_core(l >= m, 2'(l), 6'(srcs[l]));
            end
        end
        set_mask(2'h0);
        src(64'h59);
        chk_core(1'b1, 2'h3, 6'h00);
        src(64'h0);
        $display("end t_mask");
    endtask

    task automatic t_nest;
        src(64'h8);
        take_it();
        look();
        chk_core(1'b0, 2'h0, 6'h00);
        src(64'h18);
        chk_core(1'b1, 2'h1, 6'h04);
        take_it();
        look();
        chk_core(1'b0, 2'h0, 6'h00);
        src(64'h58);
        chk_core(1'b1, 2'h2, 6'h06);
        src(64'h0);
        set_mask(2'h0);
        $display("end t_nest");
    endtask

    task automatic t_fast;
        set_pri(9, 2'h3);
        wr(PIA_IDX_FM0, 32'h6);
        wr(PIA_IDX_FVL0, 32'hbeef);
        wr(PIA_IDX_FVH0, 32'h15);
        src(64'h40);
        chk({31'h0, fast_irq}, 32'h1);
        chk({11'h0, vector_addr}, {11'h0, 5'h15, 16'hbeef});
        take_it();
        chk({31'h0, fast_taken}, 32'h1);
        set_mask(2'h0);
        wr(PIA_IDX_FM1, 32'h4);
        src(64'h10);
        chk({31'h0, fast_irq}, 32'h0);
        chk({11'h0, vector_addr}, {12'h0, VB, 6'h04});
        wr(PIA_IDX_FM1, 32'h9);
        wr(PIA_IDX_FVL1, 32'h1234);
        wr(PIA_IDX_FVH1, 32'h0a);
        src(64'h200);
        chk({11'h0, vector_addr}, {11'h0, 5'h0a, 16'h1234});
        src(64'h0);
        $display("end t_fast");
    endtask

    // Frozen clock enable: outputs hold and the bus is not answered
    task automatic t_ce;
        @(posedge pclk);
        ce <= 1'b0;
        src(64'h8);
        chk({30'h0, pready, core_irq}, 32'h0);
        @(posedge pclk);
        ce <= 1'b1;
        look();
        chk_core(1'b1, 2'h0, 6'h03);
        src(64'h0);
        $display("end t_ce");
    endtask

    task automatic t_stat;
        wr(PIA_IDX_IEN, 32'h0);
        wr(PIA_IDX_CLR, 32'h7);
        rd(PIA_IDX_STAT, 32'h0);
        src(64'h8);
        rd(PIA_IDX_STAT, 32'h1);
        chk({31'h0, irq}, 32'h0);
        wr(PIA_IDX_IEN, 32'h1);
        look();
        chk({31'h0, irq}, 32'h1);
        wr(PIA_IDX_STAT, 32'h0);
        rd(PIA_IDX_STAT, 32'h1);
        src(64'h0);
        wr(PIA_IDX_CLR, 32'h1);
        look();
        chk({31'h0, irq}, 32'h0);
        rd(PIA_IDX_CLR, 32'h0);
        $display("end t_stat");
    endtask

    task automatic t_wake;
        @(posedge pclk);
        low_power_mode <= 1'b1;
        src(64'h400);
        chk({31'h0, wake_req}, 32'h0);
        src(64'h8);
        chk({31'h0, wake_req}, 32'h1);
        set_pri(12, 2'h1);
        src(64'h1000);
        chk({31'h0, wake_req}, 32'h0);
        @(posedge pclk);
        low_power_mode <= 1'b0;
        src(64'h0);
        rd(PIA_IDX_STAT, 32'h5);
        $display("end t_wake");
    endtask

    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_within();
        t_mask();
        t_nest();
        t_fast();
        t_ce();
        t_stat();
        t_wake();
        wrap_up();
    end
endmodule // tb
